// ---- hdl/ucrd_defines.svh ----
// Offsets, field positions, masks and reset values of the channel decode.
`ifndef UCRD_DEFINES_SVH
`define UCRD_DEFINES_SVH

// ****************************************************************
// Register offsets inside one channel
// ****************************************************************
`define UCRD_OFF_DATA 3'h0
`define UCRD_OFF_IER 3'h1
`define UCRD_OFF_ISR 3'h2
`define UCRD_OFF_LCR 3'h3
`define UCRD_OFF_MCR 3'h4
`define UCRD_OFF_LSR 3'h5
`define UCRD_OFF_MSR 3'h6
`define UCRD_OFF_SPR 3'h7

// ****************************************************************
// Field positions, keys and masks
// ****************************************************************
`define UCRD_LCR_KEY 8'hBF
`define UCRD_LCR_DLAB 7
`define UCRD_EFR_ENH 4
`define UCRD_FEATURE_CONTROL_SWAP 6
`define UCRD_FCR_EN 0
`define UCRD_FCR_RXRST 1
`define UCRD_FCR_TXRST 2
`define UCRD_ENHANCED_MODE_SELECT_TXSEL 0
`define UCRD_FCR_SELFCLR 8'h06
`define UCRD_IER_ENH 8'hF0
`define UCRD_FCR_ENH 8'h30
`define UCRD_MCR_ENH 8'hE0
`define UCRD_ISR_ENH 6'h30
`define UCRD_ENHANCED_MODE_SELECT_RSVD 8'hC0
`define UCRD_ALL_ONES 8'hFF

// ****************************************************************
// Reset values
// ****************************************************************
`define UCRD_RST_BYTE 8'h00
`define UCRD_DIV_ZERO 16'h0000

`endif

// ---- hdl/ucrd_pkg.sv ----
// Types shared by the channel decode modules.
`default_nettype none

package ucrd_pkg;
	typedef logic [7:0] ucrd_byte_t;
	typedef logic [1:0] ucrd_chan_t;
	typedef enum logic [1:0] {UCRD_NORMAL, UCRD_DIVISOR, UCRD_KEYED}
		ucrd_mode_t;
endpackage

`default_nettype wire

// ---- hdl/ucrd_msr_if.sv ----
// Carrier between the decode and one modem status tracker.
`timescale 1ns/1ps
`default_nettype none

interface ucrd_msr_if;
	logic [3:0] level;
	logic clear;
	logic [7:0] status;
	modport tracker (input level, input clear, output status);
	modport owner (output level, output clear, input status);
endinterface

`default_nettype wire

// ---- hdl/ucrd_sync.sv ----
// Two-stage synchroniser for pin inputs.
`timescale 1ns/1ps
`default_nettype none

module ucrd_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST_VAL = '0
) (
	// Clock, reset and enable
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// Pin side
	input wire logic [W-1:0] pin_in,
	// Clock side
	output logic [W-1:0] pin_q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] hold_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			meta_ff <= RST_VAL;
			hold_ff <= RST_VAL;
		end else if (clk_en) begin
			meta_ff <= pin_in;
			hold_ff <= meta_ff;
		end
	end

	assign pin_q = hold_ff;
endmodule // ucrd_sync

`default_nettype wire

// ---- hdl/ucrd_msr.sv ----
// Modem status tracker: current levels and sticky change flags.
`timescale 1ns/1ps
`default_nettype none

module ucrd_msr (
	// Clock, reset and enable
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// Tracker side of the carrier
	ucrd_msr_if.tracker msr
);
	logic [3:0] prev_ff;
	logic [3:0] delta_ff;
	logic prime_ff;
	logic [3:0] change_w;
	logic [3:0] nxt_delta;

	// The first sample after reset only primes the history; a pin that sits
	// asserted at start-up still raises a change once it leaves the synchroniser.
	assign change_w = prime_ff ? (msr.level ^ prev_ff) : 4'h0;
	// A change seen in the clearing read cycle survives the clear.
	assign nxt_delta = change_w | (msr.clear ? 4'h0 : delta_ff);

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			prev_ff <= 4'h0;
			delta_ff <= 4'h0;
			prime_ff <= 1'b0;
		end else if (clk_en) begin
			prev_ff <= msr.level;
			delta_ff <= nxt_delta;
			prime_ff <= 1'b1;
		end
	end

	assign msr.status = {msr.level, delta_ff};

	delta_set_a: assert property (@(posedge clock) disable iff (rst)
		(clk_en && prime_ff && (msr.level != prev_ff)) |=>
		((delta_ff & $past(change_w)) == $past(change_w)))
		else $error("modem change not flagged");
endmodule // ucrd_msr

`default_nettype wire

// ---- hdl/ucrd_top.sv ----
// Channel register decode: four register sets behind one host port.
//
// How it works
// - Four channels each own registers; channel select then address picks one.
// - Offset 0, divisor bit clear: read receive byte, write transmit byte.
// - Divisor bit set, not key: offsets 0 and 1 hold the divisor bytes.
// - Divisor zero in divisor mode: offsets 0, 1 read revision and identity.
// - Offset 1 normal mode is interrupt enable, eight documented bits.
// - Offset 2 read gives interrupt status with FIFO-enabled bits on top.
// - Offset 2 write is FIFO control: triggers, DMA, FIFO resets, enable.
// - Offset 3 line control is read/write in every mode.
// - Offset 4 normal mode is modem control with eight control bits.
// - Offset 5 reads line status; writes there are ignored.
// - Offset 6 reads modem levels and change flags; writes ignored.
// - Offset 7 with swap bit clear is a scratch byte.
// - Offset 7 with swap bit set reads FIFO level, writes mode select.
// - Mode select holds hysteresis, DMA enables and level count select.
// - Key mode offset 0 writes trigger level, reads FIFO level.
// - Key mode offset 1 is feature control.
// - Key mode offset 2 is enhanced function.
// - Key mode offsets 4 to 7 are the four flow characters.
// - Status select pin low makes any read return FIFO ready summary.
// - Enhanced bits act only while enhanced function bit 4 is set.
`timescale 1ns/1ps
`default_nettype none
`include "ucrd_defines.svh"

module ucrd_top import ucrd_pkg::*; #(
	parameter ucrd_byte_t REV_CODE = 8'h01, // Arbitrary value.
	parameter ucrd_byte_t DEV_ID = 8'h5A // Arbitrary value.
) (
	// Clock, reset and enable
	input wire logic clock,
	input wire logic rst,
	input wire logic clk_en,
	// Host register port
	input wire ucrd_chan_t ch_sel,
	input wire logic [2:0] addr,
	input wire logic rd_stb,
	input wire logic wr_stb,
	input wire ucrd_byte_t wr_data,
	output ucrd_byte_t rd_data,
	output logic rd_valid,
	// Pins
	input wire logic status_select_pin_n,
	input wire logic [15:0] modem_pin_n,
	// Datapath status, four channels packed low channel first
	input wire logic [31:0] rx_byte,
	input wire logic [31:0] line_stat,
	input wire logic [23:0] int_src,
	input wire logic [31:0] rx_count,
	input wire logic [31:0] tx_count,
	input wire logic [3:0] rx_ready_n,
	input wire logic [3:0] tx_ready_n,
	// Datapath strobes
	output logic [3:0] tx_load,
	output ucrd_byte_t tx_data,
	output logic [3:0] rx_taken,
	output logic [3:0] tx_fifo_rst,
	output logic [3:0] rx_fifo_rst,
	// Datapath configuration
	output logic [63:0] baud_div,
	output logic [31:0] line_ctrl,
	output logic [31:0] int_enable,
	output logic [31:0] fifo_ctrl,
	output logic [31:0] modem_ctrl,
	output logic [31:0] feat_ctrl,
	output logic [31:0] enh_func,
	output logic [31:0] trig_level,
	output logic [31:0] mode_select,
	output logic [127:0] flow_chars
);
	localparam int NCH = 4;

	// ****************************************************************
	// Pin synchronisers
	// ****************************************************************
	logic stat_n_q;
	logic [15:0] modem_q;

	ucrd_sync #(.W(1), .RST_VAL(1'b1)) u_sync_stat (
		.clock(clock),
		.rst(rst),
		.clk_en(clk_en),
		.pin_in(status_select_pin_n),
		.pin_q(stat_n_q)
	);

	ucrd_sync #(.W(16), .RST_VAL(16'hFFFF)) u_sync_modem (
		.clock(clock),
		.rst(rst),
		.clk_en(clk_en),
		.pin_in(modem_pin_n),
		.pin_q(modem_q)
	);

	// ****************************************************************
	// Per-channel views and selected channel
	// ****************************************************************
	ucrd_byte_t lcr_a [NCH];
	ucrd_byte_t ier_a [NCH];
	ucrd_byte_t fcr_a [NCH];
	ucrd_byte_t mcr_a [NCH];
	ucrd_byte_t spr_a [NCH];
	ucrd_byte_t enhanced_mode_select_a [NCH];
	ucrd_byte_t feature_control_a [NCH];
	ucrd_byte_t efr_a [NCH];
	ucrd_byte_t dll_a [NCH];
	ucrd_byte_t dlm_a [NCH];
	ucrd_byte_t msr_a [NCH];
	ucrd_byte_t flow_a [NCH][4];

	ucrd_byte_t lcr_sel;
	ucrd_byte_t ier_sel;
	ucrd_byte_t fcr_sel;
	ucrd_byte_t mcr_sel;
	ucrd_byte_t efr_sel;
	ucrd_byte_t feature_control_sel;
	ucrd_byte_t enhanced_mode_select_sel;
	logic [4:0] byte_idx;
	logic [4:0] src_idx;
	logic [3:0] onehot_w;

	assign lcr_sel = lcr_a[ch_sel];
	assign ier_sel = ier_a[ch_sel];
	assign fcr_sel = fcr_a[ch_sel];
	assign mcr_sel = mcr_a[ch_sel];
	assign efr_sel = efr_a[ch_sel];
	assign feature_control_sel = feature_control_a[ch_sel];
	assign enhanced_mode_select_sel = enhanced_mode_select_a[ch_sel];
	assign byte_idx = {ch_sel, 3'h0};
	assign src_idx = {1'b0, ch_sel, 2'h0} + {2'h0, ch_sel, 1'b0};
	assign onehot_w = 4'(4'h1 << ch_sel);

	// ****************************************************************
	// Mode decode
	// ****************************************************************
	ucrd_mode_t mode_w;
	logic plain_w;
	logic keyed_w;
	logic enh_w;
	logic swap_w;
	logic div_zero_w;
	logic rd_msr_w;

	// The key value wins over the divisor bit, since the key has it set.
	assign mode_w = (lcr_sel == `UCRD_LCR_KEY) ? UCRD_KEYED :
		lcr_sel[`UCRD_LCR_DLAB] ? UCRD_DIVISOR : UCRD_NORMAL;
	assign plain_w = (mode_w != UCRD_KEYED);
	assign keyed_w = (mode_w == UCRD_KEYED);
	assign enh_w = efr_sel[`UCRD_EFR_ENH];
	assign swap_w = feature_control_sel[`UCRD_FEATURE_CONTROL_SWAP];
	assign div_zero_w = ({dlm_a[ch_sel], dll_a[ch_sel]} == `UCRD_DIV_ZERO);

	// ****************************************************************
	// Write decode
	// ****************************************************************
	logic a_data;
	logic a_ier;
	logic a_isr;
	logic a_lcr;
	logic a_mcr;
	logic a_msr;
	logic a_spr;
	logic we_thr;
	logic we_dll;
	logic we_dlm;
	logic we_ier;
	logic we_fcr;
	logic we_lcr;
	logic we_mcr;
	logic we_spr;
	logic we_enhanced_mode_select;
	logic we_trg;
	logic we_feature_control;
	logic we_efr;
	logic we_flow;

	assign a_data = (addr == `UCRD_OFF_DATA);
	assign a_ier = (addr == `UCRD_OFF_IER);
	assign a_isr = (addr == `UCRD_OFF_ISR);
	assign a_lcr = (addr == `UCRD_OFF_LCR);
	assign a_mcr = (addr == `UCRD_OFF_MCR);
	assign a_msr = (addr == `UCRD_OFF_MSR);
	assign a_spr = (addr == `UCRD_OFF_SPR);

	assign we_thr = wr_stb && (mode_w == UCRD_NORMAL) && a_data;
	assign we_dll = wr_stb && (mode_w == UCRD_DIVISOR) && a_data;
	assign we_dlm = wr_stb && (mode_w == UCRD_DIVISOR) && a_ier;
	assign we_ier = wr_stb && (mode_w == UCRD_NORMAL) && a_ier;
	assign we_fcr = wr_stb && plain_w && a_isr;
	assign we_lcr = wr_stb && a_lcr;
	assign we_mcr = wr_stb && plain_w && a_mcr;
	assign we_spr = wr_stb && plain_w && a_spr && !swap_w;
	assign we_enhanced_mode_select = wr_stb && plain_w && a_spr && swap_w;
	assign we_trg = wr_stb && keyed_w && a_data;
	assign we_feature_control = wr_stb && keyed_w && a_ier;
	assign we_efr = wr_stb && keyed_w && a_isr;
	assign we_flow = wr_stb && keyed_w && addr[2];

	// Gated bits keep their old value on a write while enhancements are off.
	ucrd_byte_t gate_ier;
	ucrd_byte_t gate_fcr;
	ucrd_byte_t gate_mcr;
	ucrd_byte_t nxt_enhanced_mode_select;

	assign gate_ier = enh_w ? `UCRD_ALL_ONES : ~`UCRD_IER_ENH;
	assign gate_fcr = enh_w ? `UCRD_ALL_ONES : ~`UCRD_FCR_ENH;
	assign gate_mcr = enh_w ? `UCRD_ALL_ONES : ~`UCRD_MCR_ENH;
	assign nxt_enhanced_mode_select = wr_data & ~`UCRD_ENHANCED_MODE_SELECT_RSVD;

	// ****************************************************************
	// Register sets, one per channel
	// ****************************************************************
	for (genvar i = 0; i < NCH; i++) begin : g_ch
		ucrd_byte_t lcr_ff;
		ucrd_byte_t ier_ff;
		ucrd_byte_t fcr_ff;
		ucrd_byte_t mcr_ff;
		ucrd_byte_t spr_ff;
		ucrd_byte_t enhanced_mode_select_ff;
		ucrd_byte_t trg_ff;
		ucrd_byte_t feature_control_ff;
		ucrd_byte_t efr_ff;
		ucrd_byte_t dll_ff;
		ucrd_byte_t dlm_ff;
		ucrd_byte_t flow_ff [4];
		logic hit;
		ucrd_byte_t out_ier;
		ucrd_byte_t out_fcr;
		ucrd_byte_t out_mcr;
		ucrd_byte_t nxt_ier;
		ucrd_byte_t nxt_fcr;
		ucrd_byte_t nxt_mcr;

		assign hit = clk_en && (ch_sel == ucrd_chan_t'(i));
		// Kept bits come from the raw flops; the outputs show them as zero.
		assign nxt_ier = (wr_data & gate_ier) | (ier_ff & ~gate_ier);
		// Reset bits act as pulses and never stay set in the register.
		assign nxt_fcr = ((wr_data & gate_fcr) | (fcr_ff & ~gate_fcr)) &
			~`UCRD_FCR_SELFCLR;
		assign nxt_mcr = (wr_data & gate_mcr) | (mcr_ff & ~gate_mcr);

		always_ff @(posedge clock or posedge rst) begin
			if (rst) begin
				lcr_ff <= `UCRD_RST_BYTE;
				ier_ff <= `UCRD_RST_BYTE;
				fcr_ff <= `UCRD_RST_BYTE;
				mcr_ff <= `UCRD_RST_BYTE;
				spr_ff <= `UCRD_RST_BYTE;
				enhanced_mode_select_ff <= `UCRD_RST_BYTE;
				trg_ff <= `UCRD_RST_BYTE;
				feature_control_ff <= `UCRD_RST_BYTE;
				efr_ff <= `UCRD_RST_BYTE;
				dll_ff <= `UCRD_RST_BYTE;
				dlm_ff <= `UCRD_RST_BYTE;
				for (int k = 0; k < 4; k++) begin
					flow_ff[k] <= `UCRD_RST_BYTE;
				end
			end else if (hit) begin
				if (we_lcr) lcr_ff <= wr_data;
				if (we_ier) ier_ff <= nxt_ier;
				if (we_fcr) fcr_ff <= nxt_fcr;
				if (we_mcr) mcr_ff <= nxt_mcr;
				if (we_spr) spr_ff <= wr_data;
				if (we_enhanced_mode_select) enhanced_mode_select_ff <= nxt_enhanced_mode_select;
				if (we_trg) trg_ff <= wr_data;
				if (we_feature_control) feature_control_ff <= wr_data;
				if (we_efr) efr_ff <= wr_data;
				if (we_dll) dll_ff <= wr_data;
				if (we_dlm) dlm_ff <= wr_data;
				if (we_flow) flow_ff[addr[1:0]] <= wr_data;
			end
		end

		// Gated bits read and drive as zero while enhancements are off.
		assign out_ier = efr_ff[`UCRD_EFR_ENH] ? ier_ff :
			(ier_ff & ~`UCRD_IER_ENH);
		assign out_fcr = efr_ff[`UCRD_EFR_ENH] ? fcr_ff :
			(fcr_ff & ~`UCRD_FCR_ENH);
		assign out_mcr = efr_ff[`UCRD_EFR_ENH] ? mcr_ff :
			(mcr_ff & ~`UCRD_MCR_ENH);

		assign lcr_a[i] = lcr_ff;
		assign ier_a[i] = out_ier;
		assign fcr_a[i] = out_fcr;
		assign mcr_a[i] = out_mcr;
		assign spr_a[i] = spr_ff;
		assign enhanced_mode_select_a[i] = enhanced_mode_select_ff;
		assign feature_control_a[i] = feature_control_ff;
		assign efr_a[i] = efr_ff;
		assign dll_a[i] = dll_ff;
		assign dlm_a[i] = dlm_ff;
		for (genvar k = 0; k < 4; k++) begin : g_flow
			assign flow_a[i][k] = flow_ff[k];
			assign flow_chars[32*i+8*k +: 8] = flow_ff[k];
		end

		assign baud_div[16*i +: 16] = {dlm_ff, dll_ff};
		assign line_ctrl[8*i +: 8] = lcr_ff;
		assign int_enable[8*i +: 8] = out_ier;
		assign fifo_ctrl[8*i +: 8] = out_fcr;
		assign modem_ctrl[8*i +: 8] = out_mcr;
		assign feat_ctrl[8*i +: 8] = feature_control_ff;
		assign enh_func[8*i +: 8] = efr_ff;
		assign trig_level[8*i +: 8] = trg_ff;
		assign mode_select[8*i +: 8] = enhanced_mode_select_ff;

		// Modem status: pins are active low, status shows asserted levels.
		ucrd_msr_if msr_if ();
		assign msr_if.level = ~modem_q[4*i +: 4];
		assign msr_if.clear = rd_msr_w && (ch_sel == ucrd_chan_t'(i));
		assign msr_a[i] = msr_if.status;

		ucrd_msr u_msr (
			.clock(clock),
			.rst(rst),
			.clk_en(clk_en),
			.msr(msr_if.tracker)
		);
	end

	// ****************************************************************
	// Read selection
	// ****************************************************************
	ucrd_byte_t level_w;
	ucrd_byte_t isr_w;
	ucrd_byte_t fifo_ready_summary_w;
	ucrd_byte_t norm_rd [8];
	ucrd_byte_t key_rd [8];
	ucrd_byte_t div_rd;
	ucrd_byte_t rd_mux_w;
	logic [5:0] src_w;
	logic rd_live;
	logic rd_rhr_w;

	assign level_w = enhanced_mode_select_sel[`UCRD_ENHANCED_MODE_SELECT_TXSEL] ? tx_count[byte_idx +: 8] :
		rx_count[byte_idx +: 8];
	assign src_w = int_src[src_idx +: 6];
	assign isr_w = {{2{fcr_sel[`UCRD_FCR_EN]}},
		enh_w ? src_w : (src_w & ~`UCRD_ISR_ENH)};
	assign fifo_ready_summary_w = {rx_ready_n, tx_ready_n};

	assign norm_rd[0] = rx_byte[byte_idx +: 8];
	assign norm_rd[1] = ier_sel;
	assign norm_rd[2] = isr_w;
	assign norm_rd[3] = lcr_sel;
	assign norm_rd[4] = mcr_sel;
	assign norm_rd[5] = line_stat[byte_idx +: 8];
	assign norm_rd[6] = msr_a[ch_sel];
	assign norm_rd[7] = swap_w ? level_w : spr_a[ch_sel];

	assign key_rd[0] = level_w;
	assign key_rd[1] = feature_control_sel;
	assign key_rd[2] = efr_sel;
	assign key_rd[3] = lcr_sel;
	for (genvar k = 0; k < 4; k++) begin : g_key_rd
		assign key_rd[4+k] = flow_a[ch_sel][k];
	end

	// Offsets above the divisor pair keep their normal meaning here.
	assign div_rd = a_data ? (div_zero_w ? REV_CODE : dll_a[ch_sel]) :
		a_ier ? (div_zero_w ? DEV_ID : dlm_a[ch_sel]) :
		norm_rd[addr];

	assign rd_mux_w = !stat_n_q ? fifo_ready_summary_w :
		keyed_w ? key_rd[addr] :
		(mode_w == UCRD_DIVISOR) ? div_rd : norm_rd[addr];

	// A status summary read touches no channel, so it has no side effect.
	assign rd_live = rd_stb && stat_n_q;
	assign rd_rhr_w = rd_live && (mode_w == UCRD_NORMAL) && a_data;
	assign rd_msr_w = rd_live && plain_w && a_msr;

	// ****************************************************************
	// Read data and datapath strobes
	// ****************************************************************
	ucrd_byte_t rd_data_ff;
	ucrd_byte_t tx_data_ff;
	logic rd_valid_ff;
	logic [3:0] tx_load_ff;
	logic [3:0] rx_taken_ff;
	logic [3:0] tx_rst_ff;
	logic [3:0] rx_rst_ff;

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			rd_data_ff <= `UCRD_RST_BYTE;
			rd_valid_ff <= 1'b0;
		end else if (clk_en) begin
			if (rd_stb) rd_data_ff <= rd_mux_w;
			rd_valid_ff <= rd_stb;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			tx_data_ff <= `UCRD_RST_BYTE;
			tx_load_ff <= 4'h0;
			rx_taken_ff <= 4'h0;
			tx_rst_ff <= 4'h0;
			rx_rst_ff <= 4'h0;
		end else if (clk_en) begin
			if (we_thr) tx_data_ff <= wr_data;
			tx_load_ff <= we_thr ? onehot_w : 4'h0;
			rx_taken_ff <= rd_rhr_w ? onehot_w : 4'h0;
			tx_rst_ff <= (we_fcr && wr_data[`UCRD_FCR_TXRST]) ?
				onehot_w : 4'h0;
			rx_rst_ff <= (we_fcr && wr_data[`UCRD_FCR_RXRST]) ?
				onehot_w : 4'h0;
		end
	end

	assign rd_data = rd_data_ff;
	assign rd_valid = rd_valid_ff;
	assign tx_data = tx_data_ff;
	assign tx_load = tx_load_ff;
	assign rx_taken = rx_taken_ff;
	assign tx_fifo_rst = tx_rst_ff;
	assign rx_fifo_rst = rx_rst_ff;

	// ****************************************************************
	// Checks
	// ****************************************************************
	fifo_ready_summary_read_a: assert property (@(posedge clock) disable iff (rst)
		(clk_en && rd_stb && !stat_n_q) |=>
		(rd_valid && rd_data == $past({rx_ready_n, tx_ready_n})))
		else $error("status summary read wrong");

	thr_load_a: assert property (@(posedge clock) disable iff (rst)
		(clk_en && wr_stb && addr == 3'h0 && !lcr_sel[7]) |=>
		(tx_load == $past(onehot_w) && tx_data == $past(wr_data)))
		else $error("transmit byte not loaded");

	lcr_write_a: assert property (@(posedge clock) disable iff (rst)
		(clk_en && wr_stb && addr == 3'h3) |=>
		(line_ctrl[{$past(ch_sel), 3'h0} +: 8] == $past(wr_data)))
		else $error("line control not written");

	div_low_a: assert property (@(posedge clock) disable iff (rst)
		(clk_en && wr_stb && addr == 3'h0 && lcr_sel[7] &&
		lcr_sel != 8'hBF) |=>
		(baud_div[{$past(ch_sel), 4'h0} +: 8] == $past(wr_data) &&
		tx_load == 4'h0))
		else $error("divisor low byte not written");

	dev_ident_a: assert property (@(posedge clock) disable iff (rst)
		(clk_en && rd_stb && stat_n_q && addr == 3'h1 && lcr_sel[7] &&
		lcr_sel != 8'hBF && div_zero_w) |=> (rd_data == DEV_ID))
		else $error("identity code not returned");

	ier_gate_a: assert property (@(posedge clock) disable iff (rst)
		(clk_en && rd_stb && stat_n_q && addr == 3'h1 && !lcr_sel[7] &&
		!efr_sel[4]) |=> (rd_data[7:4] == 4'h0))
		else $error("gated enable bits read nonzero");

	fifo_reset_a: assert property (@(posedge clock) disable iff (rst)
		(clk_en && wr_stb && addr == 3'h2 && lcr_sel != 8'hBF &&
		wr_data[1]) |=> (rx_fifo_rst == $past(onehot_w) &&
		fifo_ctrl[{$past(ch_sel), 3'h0} + 5'd1] == 1'b0))
		else $error("receive FIFO reset pulse missing");

	level_read_a: assert property (@(posedge clock) disable iff (rst)
		(clk_en && rd_stb && stat_n_q && addr == 3'h7 && !lcr_sel[7] &&
		feature_control_sel[6]) |=> (rd_data == $past(level_w)))
		else $error("FIFO level not returned");

	flow_char_a: assert property (@(posedge clock) disable iff (rst)
		(clk_en && wr_stb && addr == 3'h5 && lcr_sel == 8'hBF) |=>
		(flow_chars[{$past(ch_sel), 5'h08} +: 8] == $past(wr_data)))
		else $error("flow character not written");
endmodule // ucrd_top

`default_nettype wire

// ---- tb/ucrd_datapath_model.sv ----
// Datapath stand-in that feeds status bytes and catches transmit bytes.
`timescale 1ns/1ps
`default_nettype none

module ucrd_datapath_model (
	// Clock
	input wire logic clock,
	// Status toward the decode
	output logic [31:0] rx_byte,
	output logic [31:0] line_stat,
	output logic [23:0] int_src,
	output logic [31:0] rx_count,
	output logic [31:0] tx_count,
	output logic [3:0] rx_ready_n,
	output logic [3:0] tx_ready_n,
	// Transmit side seen from the decode
	input wire logic [3:0] tx_load,
	input wire logic [7:0] tx_data,
	output logic [7:0] last_tx,
	output logic [3:0] last_ch
);
	// Every channel differs so a wrong channel pick shows on a read.
	assign rx_byte = 32'hA3A2A1A0;
	assign line_stat = 32'h63626160;
	// The top source bits are set so that their gating is visible.
	assign int_src = {6'h34, 6'h33, 6'h32, 6'h31};
	assign rx_count = 32'h13121110;
	assign tx_count = 32'h23222120;
	assign rx_ready_n = 4'h5;
	assign tx_ready_n = 4'hA;
	always_ff @(posedge clock) begin
		if (|tx_load) begin
			last_tx <= tx_data;
			last_ch <= tx_load;
		end
	end
endmodule // ucrd_datapath_model

`default_nettype wire

// ---- tb/test_ucrd_top.sv ----
// Self-checking bench for the channel register decode.
`timescale 1ns/1ps
`default_nettype none

module test_ucrd_top import ucrd_pkg::*;;
	typedef struct packed {
		ucrd_chan_t ch;
		ucrd_byte_t line_control;
		logic [2:0] a;
		logic w;
		ucrd_byte_t d;
		ucrd_byte_t e;
	} ucrd_row_t;
	logic clock = 1'h0, rst = 1'h1, clk_en = 1'h1;
	ucrd_chan_t ch_sel = '0;
	logic [2:0] addr = '0;
	logic rd_stb = 1'h0, wr_stb = 1'h0, ss_n = 1'h1, rd_valid;
	ucrd_byte_t wr_data = '0, rd_data, tx_data, last_tx;
	logic [15:0] pins_n = 16'hFFFF;
	logic [31:0] rx_byte, line_stat, rx_count, tx_count, line_ctrl;
	logic [31:0] int_enable, trig_level, mode_select;
	logic [3:0] rx_taken;
	logic [23:0] int_src;
	logic [3:0] rx_ready_n, tx_ready_n, tx_load, last_ch;
	int mismatches = 0, num_checks = 0, cycles = 0;
	ucrd_row_t rows[21] = '{
		'{2'h0, 8'h00, 3'h0, 1'h0, 8'h00, 8'hA0},
		'{2'h1, 8'h00, 3'h1, 1'h1, 8'h5F, 8'h0F},
		'{2'h2, 8'h00, 3'h4, 1'h1, 8'hFF, 8'h1F},
		'{2'h3, 8'h00, 3'h7, 1'h1, 8'h3C, 8'h3C},
		'{2'h0, 8'h00, 3'h5, 1'h1, 8'h00, 8'h60},
		'{2'h1, 8'h00, 3'h2, 1'h0, 8'h00, 8'h02},
		'{2'h1, 8'h00, 3'h2, 1'h1, 8'h01, 8'hC2},
		'{2'h2, 8'h80, 3'h0, 1'h1, 8'h34, 8'h34},
		'{2'h3, 8'h80, 3'h0, 1'h0, 8'h00, 8'h3C},
		'{2'h3, 8'h80, 3'h1, 1'h0, 8'h00, 8'hC3},
		'{2'h2, 8'h80, 3'h1, 1'h0, 8'h00, 8'h00},
		'{2'h0, 8'hBF, 3'h1, 1'h1, 8'h40, 8'h40},
		'{2'h0, 8'hBF, 3'h2, 1'h1, 8'h10, 8'h10},
		'{2'h0, 8'hBF, 3'h4, 1'h1, 8'h11, 8'h11},
		'{2'h0, 8'hBF, 3'h5, 1'h1, 8'h22, 8'h22},
		'{2'h0, 8'hBF, 3'h6, 1'h1, 8'h33, 8'h33},
		'{2'h0, 8'hBF, 3'h7, 1'h1, 8'h44, 8'h44},
		'{2'h0, 8'hBF, 3'h0, 1'h0, 8'h00, 8'h10},
		'{2'h0, 8'h00, 3'h7, 1'h1, 8'h01, 8'h20},
		'{2'h0, 8'h00, 3'h1, 1'h1, 8'hF3, 8'hF3},
		'{2'h0, 8'h03, 3'h3, 1'h0, 8'h00, 8'h03}
	};

	// ******************************
	// Design and datapath stand-in
	// ******************************
	ucrd_top #(.REV_CODE(8'h3C), .DEV_ID(8'hC3)) ucrd_top_i (
		.clock(clock), .rst(rst), .clk_en(clk_en), .ch_sel(ch_sel),
		.addr(addr), .rd_stb(rd_stb), .wr_stb(wr_stb), .wr_data(wr_data),
		.rd_data(rd_data), .rd_valid(rd_valid),
		.status_select_pin_n(ss_n), .modem_pin_n(pins_n),
		.rx_byte(rx_byte), .line_stat(line_stat), .int_src(int_src),
		.rx_count(rx_count), .tx_count(tx_count),
		.rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n),
		.tx_load(tx_load), .tx_data(tx_data), .rx_taken(rx_taken),
		.tx_fifo_rst(), .rx_fifo_rst(), .baud_div(),
		.line_ctrl(line_ctrl), .int_enable(int_enable), .fifo_ctrl(),
		.modem_ctrl(), .feat_ctrl(), .enh_func(),
		.trig_level(trig_level), .mode_select(mode_select),
		.flow_chars()
	);
	ucrd_datapath_model ucrd_datapath_model_i (
		.clock(clock), .rx_byte(rx_byte), .line_stat(line_stat),
		.int_src(int_src), .rx_count(rx_count), .tx_count(tx_count),
		.rx_ready_n(rx_ready_n), .tx_ready_n(tx_ready_n),
		.tx_load(tx_load), .tx_data(tx_data), .last_tx(last_tx),
		.last_ch(last_ch)
	);

	// ******************************
	// Tasks
	// ******************************
	task automatic close_out();
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	task automatic chk(string what, ucrd_byte_t exp, ucrd_byte_t got);
		num_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("unexpected %s: expected %h seen %h", what, exp, got);
		end
	endtask

	// One strobe cycle; read data is left on rd_data for the caller.
	task automatic acc(ucrd_chan_t c, logic [2:0] a, logic w, ucrd_byte_t d);
		@(posedge clock);
		ch_sel <= c;
		addr <= a;
		wr_data <= d;
		wr_stb <= w;
		rd_stb <= !w;
		@(posedge clock);
		wr_stb <= 1'h0;
		rd_stb <= 1'h0;
		@(negedge clock);
		if (!w)
			chk("rd_valid", 8'h01, {7'h00, rd_valid});
	endtask

	always #5 clock = ~clock;

	// The whole run needs well under a thousand cycles.
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 5000) begin
			mismatches++;
			close_out();
		end
	end

	// ******************************
	// Tests
	// ******************************
	initial begin
		repeat (4) @(posedge clock);
		rst <= 1'h0;
		@(negedge clock);
		chk("rd_data", 8'h00, rd_data);
		chk("tx_load", 8'h00, {4'h0, tx_load});
		$display("test reset done");
		foreach (rows[i]) begin
			acc(rows[i].ch, 3'h3, 1'h1, rows[i].line_control);
			if (rows[i].w)
				acc(rows[i].ch, rows[i].a, 1'h1, rows[i].d);
			acc(rows[i].ch, rows[i].a, 1'h0, 8'h00);
			chk("table read", rows[i].e, rd_data);
		end
		$display("test table done");
		@(posedge clock);
		ss_n <= 1'h0;
		repeat (3) @(posedge clock);
		acc(2'h1, 3'h5, 1'h0, 8'h00);
		chk("summary", 8'h5A, rd_data);
		@(posedge clock);
		ss_n <= 1'h1;
		$display("test summary done");
		acc(2'h2, 3'h3, 1'h1, 8'h00);
		@(posedge clock);
		pins_n <= 16'hFEFF;
		repeat (4) @(posedge clock);
		acc(2'h2, 3'h6, 1'h0, 8'h00);
		chk("modem change", 8'h11, rd_data);
		acc(2'h2, 3'h6, 1'h0, 8'h00);
		chk("modem cleared", 8'h10, rd_data);
		$display("test modem done");
		acc(2'h3, 3'h3, 1'h1, 8'h00);
		acc(2'h3, 3'h0, 1'h1, 8'h5E);
		@(negedge clock);
		chk("tx byte", 8'h5E, last_tx);
		chk("tx channel", 8'h08, {4'h0, last_ch});
		$display("test transmit done");
		acc(2'h0, 3'h3, 1'h1, 8'hBF);
		acc(2'h0, 3'h0, 1'h1, 8'h2A);
		chk("trig_level", 8'h2A, trig_level[7:0]);
		acc(2'h0, 3'h2, 1'h1, 8'h00);
		acc(2'h0, 3'h3, 1'h1, 8'h00);
		acc(2'h0, 3'h1, 1'h1, 8'h05);
		chk("int_enable", 8'h05, int_enable[7:0]);
		acc(2'h0, 3'h7, 1'h1, 8'hC3);
		chk("mode_select", 8'h03, mode_select[7:0]);
		acc(2'h0, 3'h0, 1'h0, 8'h00);
		chk("rx_taken", 8'h01, {4'h0, rx_taken});
		chk("rx byte", 8'hA0, rd_data);
		acc(2'h0, 3'h3, 1'h1, 8'hBF);
		acc(2'h0, 3'h2, 1'h1, 8'h10);
		chk("kept bits", 8'hF5, int_enable[7:0]);
		@(posedge clock);
		clk_en <= 1'h0;
		acc(2'h0, 3'h3, 1'h1, 8'h00);
		chk("frozen", 8'hBF, line_ctrl[7:0]);
		@(posedge clock);
		clk_en <= 1'h1;
		$display("test enhanced done");
		@(posedge clock);
		rst <= 1'h1;
		repeat (2) @(posedge clock);
		rst <= 1'h0;
		@(negedge clock);
		chk("line_ctrl", 8'h00, line_ctrl[7:0]);
		acc(2'h0, 3'h3, 1'h0, 8'h00);
		chk("line_control", 8'h00, rd_data);
		$display("test second reset done");
		close_out();
	end
endmodule // test_ucrd_top

`default_nettype wire
